// File: smc_defs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
// Register offsets (byte addresses on the register port)
`define SMC_ADDR_ENABLE 8'h60
`define SMC_ADDR_ITIME_L 8'h61
`define SMC_ADDR_ITIME_M 8'h62
`define SMC_ADDR_ITIME_H 8'h63
`define SMC_ADDR_WTIME_L 8'h64
`define SMC_ADDR_WTIME_M 8'h65
`define SMC_ADDR_WTIME_H 8'h66
`define SMC_ADDR_CLKCFG 8'h67
`define SMC_ADDR_STATUS 8'h6A
`define SMC_ADDR_TEMP 8'h6B
// Control register field positions
`define SMC_BIT_PON 0
`define SMC_BIT_MEAS_EN 1
`define SMC_BIT_THERMAL_SHUTDOWN_ENABLE 2
`define SMC_BIT_SYNC_EN 3
`define SMC_LED_LO 4
`define SMC_LED_HI 5
`define SMC_MODE_LO 6
`define SMC_MODE_HI 7
// Light source sequence codes
`define SMC_LED_OFF 2'h0
`define SMC_LED_OFF_ON 2'h1
`define SMC_LED_ON_OFF 2'h2
`define SMC_LED_ON 2'h3
// Reset values
`define SMC_RST_ENABLE 8'h00
`define SMC_RST_TIME 8'h00
`define SMC_RST_CLKSEL 3'h4
`define SMC_RST_TEMP_LIMIT 8'hC8
// Integration clock: code 100 selects 1 MHz
`define SMC_CLKSEL_1MHZ 3'h4
`define SMC_SYS_CLK_MHZ 250
`define SMC_INT_CLK_MHZ 1
`define SMC_INT_DIV (`SMC_SYS_CLK_MHZ / `SMC_INT_CLK_MHZ)
`endif

// File: smc_spectral_ctrl.v
// Spectral measurement control: registers, integration clock, measurement sequencer
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "smc_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - LED field selects off, off/on, on/off, on
// - Sync bit: start from enable or pin
// - Thermal bit allows automatic over-temperature power-down
// - Measurement enable bit gates all measurement
// - Power-on bit runs oscillator, enters idle
// - Integration time is three byte registers
// - Integrate for programmed value plus one ticks
// - Wait time three bytes, pause between measurements
// - Wait lasts programmed value plus one ticks
// - Clock select defaults to 1 MHz code
module smc_spectral_ctrl #(
	parameter DIV = `SMC_INT_DIV, // System cycles per integration clock period
	parameter TW = 24 // Width of the time settings
)(
	input wire sys_clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire sync_pin,
	input wire [7:0] temp_value,
	output reg osc_run,
	output reg integrating,
	output reg led_drive,
	output reg meas_done,
	output reg thermal_trip
);

	////////////////////////////////////////////////////////////////////////////
	// State codes
	localparam ST_OFF = 3'h0; // Oscillator stopped
	localparam ST_IDLE = 3'h1; // Powered, no measurement
	localparam ST_ARM = 3'h2; // Waiting for sync edge
	localparam ST_INT = 3'h3; // Integrating
	localparam ST_WAIT = 3'h4; // Pause between measurements

	// Registers
	reg [7:0] enable_reg; // Main control register
	reg [TW-1:0] itime_reg; // Integration time value
	reg [TW-1:0] wtime_reg; // Wait time value
	reg [2:0] clksel_reg; // Integration clock select
	reg [7:0] temp_limit_reg; // Thermal shutdown threshold
	reg [2:0] state_reg; // Sequencer state
	reg [TW-1:0] cnt_reg; // Tick counter of the phase
	reg [8:0] div_reg; // Integration clock divider
	reg meas_idx_reg; // Zero: first, one: second measurement
	reg sync_m_reg; // Sync pin first flop
	reg sync_s_reg; // Sync pin second flop
	reg sync_d_reg; // Delayed sync for edge detect
	reg [7:0] temp_m_reg; // Temperature first flop
	reg [7:0] temp_s_reg; // Temperature second flop
	reg [7:0] temp_d_reg; // Temperature third stage, for the agreement test
	reg [7:0] temp_ok_reg; // Temperature accepted after two equal samples
	reg trip_reg; // Sticky over-temperature indication

	wire power_on = enable_reg[`SMC_BIT_PON];
	wire meas_en = enable_reg[`SMC_BIT_MEAS_EN];
	wire thermal_shutdown_enable = enable_reg[`SMC_BIT_THERMAL_SHUTDOWN_ENABLE];
	wire sync_en = enable_reg[`SMC_BIT_SYNC_EN];
	wire [1:0] led_seq = enable_reg[`SMC_LED_HI:`SMC_LED_LO];
	wire sync_rise = sync_s_reg & ~sync_d_reg;
	// Integration phase decode, shared by the output flops
	wire in_int = (state_reg == ST_INT);
	// Tick only while oscillator runs and a valid clock code is selected
	// Reserved clock codes hold the integration and wait phases rather than run at a guessed rate
	wire tick = (div_reg == 9'h000) && power_on && (clksel_reg == `SMC_CLKSEL_1MHZ);
	wire over_temp = thermal_shutdown_enable && (temp_ok_reg >= temp_limit_reg);

	// Write one byte lane of a 24-bit setting
	function [TW-1:0] put_byte;
		input [TW-1:0] old;
		input [1:0] lane;
		input [7:0] val;
		begin
			put_byte = old;
			case (lane)
				2'h0: put_byte[7:0] = val;
				2'h1: put_byte[15:8] = val;
				default: put_byte[23:16] = val;
			endcase
		end
	endfunction

	// LED level for a measurement index under the sequence code
	function led_for;
		input [1:0] seq;
		input idx;
		begin
			case (seq)
				`SMC_LED_OFF: led_for = 1'b0;
				`SMC_LED_OFF_ON: led_for = idx;
				`SMC_LED_ON_OFF: led_for = ~idx;
				default: led_for = 1'b1;
			endcase
		end
	endfunction

	// Advance a phase counter by one tick
	function [TW-1:0] count_up;
		input [TW-1:0] val;
		begin
			count_up = val + {{(TW-1){1'b0}}, 1'b1};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: sync pin and temperature come from outside
	// Edge detector resets to the idle low level, so no false edge after reset
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			sync_m_reg <= 1'b0;
			sync_s_reg <= 1'b0;
			sync_d_reg <= 1'b0;
			temp_m_reg <= 8'h00;
			temp_s_reg <= 8'h00;
		end
		else
		begin
			sync_m_reg <= sync_pin;
			sync_s_reg <= sync_m_reg;
			sync_d_reg <= sync_s_reg;
			// Each bit is resynchronised on its own; see the acceptance stage
			temp_m_reg <= temp_value;
			temp_s_reg <= temp_m_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Temperature acceptance: bits are synchronised one by one, so a reading
	// caught mid-change may mix old and new bits; only two equal samples count
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			temp_d_reg <= 8'h00;
			temp_ok_reg <= 8'h00;
		end
		else
		begin
			temp_d_reg <= temp_s_reg;
			if (temp_s_reg == temp_d_reg)
				temp_ok_reg <= temp_d_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Integration clock divider, held in reset while powered down
	// The tick is the only time base, so the block keeps a single clock
	// Limitation: DIV must lie between 1 and 512 to fit the 9-bit divider
	always @(posedge sys_clk)
	begin
		if (!rst_n || !power_on)
			div_reg <= 9'h000;
		else if (div_reg == DIV[8:0] - 9'h001)
			div_reg <= 9'h000;
		else
			div_reg <= div_reg + 9'h001;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes; thermal trip clears power-on, hardware wins over host
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			enable_reg <= `SMC_RST_ENABLE;
			itime_reg <= {3{`SMC_RST_TIME}};
			wtime_reg <= {3{`SMC_RST_TIME}};
			clksel_reg <= `SMC_RST_CLKSEL;
			temp_limit_reg <= `SMC_RST_TEMP_LIMIT;
		end
		else
		begin
			if (reg_wr)
			begin
				case (reg_addr)
					`SMC_ADDR_ENABLE: enable_reg <= reg_wdata;
					// Time writes are taken as given; host must not write while enabled
					// Trade-off: no write guard, so a mid-measurement write acts at once
					`SMC_ADDR_ITIME_L: itime_reg <= put_byte(itime_reg, 2'h0, reg_wdata);
					`SMC_ADDR_ITIME_M: itime_reg <= put_byte(itime_reg, 2'h1, reg_wdata);
					`SMC_ADDR_ITIME_H: itime_reg <= put_byte(itime_reg, 2'h2, reg_wdata);
					`SMC_ADDR_WTIME_L: wtime_reg <= put_byte(wtime_reg, 2'h0, reg_wdata);
					`SMC_ADDR_WTIME_M: wtime_reg <= put_byte(wtime_reg, 2'h1, reg_wdata);
					`SMC_ADDR_WTIME_H: wtime_reg <= put_byte(wtime_reg, 2'h2, reg_wdata);
					`SMC_ADDR_CLKCFG: clksel_reg <= reg_wdata[2:0];
					`SMC_ADDR_TEMP: temp_limit_reg <= reg_wdata;
					default: ;
				endcase
			end
			if (over_temp)
				enable_reg[`SMC_BIT_PON] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, valid in the cycle after the strobe only
	always @(posedge sys_clk)
	begin
		if (!rst_n || !reg_rd)
			reg_rdata <= 8'h00;
		else
		begin
			case (reg_addr)
				`SMC_ADDR_ENABLE: reg_rdata <= enable_reg;
				`SMC_ADDR_ITIME_L: reg_rdata <= itime_reg[7:0];
				`SMC_ADDR_ITIME_M: reg_rdata <= itime_reg[15:8];
				`SMC_ADDR_ITIME_H: reg_rdata <= itime_reg[23:16];
				`SMC_ADDR_WTIME_L: reg_rdata <= wtime_reg[7:0];
				`SMC_ADDR_WTIME_M: reg_rdata <= wtime_reg[15:8];
				`SMC_ADDR_WTIME_H: reg_rdata <= wtime_reg[23:16];
				`SMC_ADDR_CLKCFG: reg_rdata <= {5'h00, clksel_reg};
				// Status: trip, measurement index and sequencer state
				`SMC_ADDR_STATUS: reg_rdata <= {3'h0, trip_reg, meas_idx_reg, state_reg};
				`SMC_ADDR_TEMP: reg_rdata <= temp_limit_reg;
				default: reg_rdata <= 8'h00; // Unmapped reads return zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky thermal trip; set wins over the host clearing it by writing power-on
	always @(posedge sys_clk)
	begin
		if (!rst_n)
			trip_reg <= 1'b0;
		else if (over_temp)
			trip_reg <= 1'b1;
		// Host clears it by powering on again
		else if (reg_wr && reg_addr == `SMC_ADDR_ENABLE && reg_wdata[`SMC_BIT_PON])
			trip_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Measurement sequencer: integrate N+1 ticks, then wait M+1 ticks, repeat
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_OFF;
			cnt_reg <= {TW{1'b0}};
			meas_idx_reg <= 1'b0;
			meas_done <= 1'b0;
		end
		else
		begin
			meas_done <= 1'b0;
			// Index and state fall back on every power-down or disable
			if (!power_on)
			begin
				state_reg <= ST_OFF;
				meas_idx_reg <= 1'b0;
			end
			else if (!meas_en && state_reg != ST_OFF)
			begin
				state_reg <= ST_IDLE;
				meas_idx_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
					ST_OFF: state_reg <= ST_IDLE;
					ST_IDLE:
					begin
						cnt_reg <= {TW{1'b0}};
						if (meas_en)
							state_reg <= sync_en ? ST_ARM : ST_INT;
					end
					ST_ARM:
					begin
						cnt_reg <= {TW{1'b0}};
						// pin assumed configured as an input by the host
						if (sync_rise)
							state_reg <= ST_INT;
					end
					// Terminal compare uses all 24 bits, so no byte is ignored
					ST_INT:
						if (tick)
						begin
							if (cnt_reg == itime_reg)
							begin
								cnt_reg <= {TW{1'b0}};
								meas_done <= 1'b1;
								meas_idx_reg <= ~meas_idx_reg;
								state_reg <= ST_WAIT;
							end
							else
								cnt_reg <= count_up(cnt_reg);
						end
					// Wait counts from zero again; next start follows the sync setting
					ST_WAIT:
						if (tick)
						begin
							if (cnt_reg == wtime_reg)
							begin
								cnt_reg <= {TW{1'b0}};
								state_reg <= sync_en ? ST_ARM : ST_INT;
							end
							else
								cnt_reg <= count_up(cnt_reg);
						end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			osc_run <= 1'b0;
			integrating <= 1'b0;
			led_drive <= 1'b0;
			thermal_trip <= 1'b0;
		end
		else
		begin
			// Oscillator indication follows power-on one cycle late
			osc_run <= power_on;
			integrating <= in_int;
			// LED only lit during integration, per the sequence code
			led_drive <= in_int && led_for(led_seq, meas_idx_reg);
			thermal_trip <= trip_reg;
		end
	end

endmodule

// File: smc_spectral_ctrl_asserts.sv
// Port timing checker for the spectral measurement control block
`timescale 1ns/100ps
module smc_chk (
	input wire sys_clk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire sync_pin,
	input wire [7:0] temp_value,
	input wire osc_run,
	input wire integrating,
	input wire led_drive,
	input wire meas_done,
	input wire thermal_trip
);
	// One clock domain, so one default clock and one reset for all
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	chk_osc_off: assert property (reg_wr && reg_addr == 8'h60 && !reg_wdata[0] |-> ##2 !osc_run)
		else $error("oscillator still running after power off");
	chk_meas_stop: assert property (reg_wr && reg_addr == 8'h60 && !reg_wdata[1] |-> ##3 !integrating)
		else $error("integration continues after disable");
	chk_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data present without a read");
	chk_led_gate: assert property (led_drive |-> integrating)
		else $error("light source driven outside integration");
	chk_done_end: assert property (meas_done |-> integrating ##1 !integrating)
		else $error("integration does not end at done");
	chk_done_once: assert property (meas_done |=> !meas_done)
		else $error("done pulse longer than one cycle");
	chk_wait_gap: assert property ($fell(integrating) |-> !integrating[*3])
		else $error("no wait between measurements");
	chk_trip_off: assert property ($rose(thermal_trip) |-> ##2 !osc_run)
		else $error("over-temperature did not power down");
endmodule

bind smc_spectral_ctrl smc_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sync_pin(sync_pin), .temp_value(temp_value), .osc_run(osc_run),
	.integrating(integrating), .led_drive(led_drive), .meas_done(meas_done),
	.thermal_trip(thermal_trip));

// File: tb_spectral_measurement_control.sv
// Register and measurement tests for the spectral measurement control block
`timescale 1ns/100ps
module tb_spectral_measurement_control;
	localparam DIV = 4; // Short integration tick keeps the run brief
	logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sync_pin = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, temp_value = 8'h00;
	wire [7:0] reg_rdata;
	wire osc_run, integrating, led_drive, meas_done, thermal_trip;
	int err_count = 0, compares = 0, done_count = 0, n, i;

	smc_spectral_ctrl #(.DIV(DIV)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sync_pin(sync_pin), .temp_value(temp_value), .osc_run(osc_run),
		.integrating(integrating), .led_drive(led_drive), .meas_done(meas_done),
		.thermal_trip(thermal_trip));

	// 250 MHz clock
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end

	// Count end-of-integration pulses
	always @(posedge sys_clk)
		if (meas_done === 1'b1)
			done_count <= done_count + 1;

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task finish_test;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compare seen against expected
	task check(input string s, input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask

	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read strobe, data looked at in the following cycle only
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 check("rdata", reg_rdata, e);
	endtask

	// Bounded wait for the integrating level; n counts the cycles
	task wt(input logic v);
		n = 0;
		while (integrating !== v && n < 400)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		if (n >= 400)
		begin
			err_count++;
			finish_test;
		end
	endtask

	// Let settled cycles pass
	task idle(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 7; i++)
			rd(8'h60 + i, 8'h00);
		rd(8'h67, 8'h04);
		rd(8'h6B, 8'hC8);
		rd(8'h6A, 8'h00);
		rd(8'h70, 8'h00);
		for (i = 1; i < 7; i++)
			wr(8'h60 + i, 8'hA0 + i);
		for (i = 1; i < 7; i++)
			rd(8'h60 + i, 8'hA0 + i);
		// Integration value 2, wait value 1
		for (i = 1; i < 7; i++)
			wr(8'h60 + i, (i == 1) ? 8'h02 : (i == 4) ? 8'h01 : 8'h00);
		$display("test registers done");
		// Every light source code over two consecutive measurements
		for (i = 0; i < 4; i++)
		begin
			wr(8'h60, 8'h01);
			idle(4);
			check("integ", integrating, 8'h00);
			check("osc", osc_run, 8'h01);
			wr(8'h60, {2'b00, i[1:0], 4'h3});
			wt(1'b1);
			idle(1);
			check("led0", led_drive, i[1]);
			wt(1'b0);
			check("ilen", n >= 8 && n <= 13, 8'h01);
			wt(1'b1);
			check("wlen", n >= 5 && n <= 10, 8'h01);
			idle(1);
			check("led1", led_drive, i[0]);
			wt(1'b0);
		end
		$display("test light source done");
		// Reserved clock code stops the ticks, so integration never ends
		wr(8'h60, 8'h01);
		wr(8'h67, 8'h05);
		wr(8'h60, 8'h03);
		wt(1'b1);
		idle(20);
		check("hold", integrating, 8'h01);
		wr(8'h60, 8'h01);
		wr(8'h67, 8'h04);
		check("done", done_count, 8'h08);
		$display("test clock select done");
		// Start held off until the sync pin rises
		wr(8'h60, 8'h01);
		wr(8'h60, 8'h0B);
		idle(20);
		check("integ", integrating, 8'h00);
		@(posedge sys_clk);
		sync_pin <= 1'b1;
		wt(1'b1);
		check("sync", n < 10, 8'h01);
		sync_pin <= 1'b0;
		$display("test sync done");
		// Power off mid-measurement; mode bits are kept and read back
		wr(8'h60, 8'hC0);
		idle(2);
		check("osc", osc_run, 8'h00);
		check("integ", integrating, 8'h00);
		rd(8'h60, 8'hC0);
		rd(8'h6A, 8'h00);
		$display("test power off done");
		// Over-temperature ignored until enabled
		wr(8'h60, 8'h01);
		temp_value <= 8'hC8;
		idle(5);
		check("osc", osc_run, 8'h01);
		wr(8'h60, 8'h05);
		idle(5);
		check("osc", osc_run, 8'h00);
		check("trip", thermal_trip, 8'h01);
		rd(8'h60, 8'h04);
		rd(8'h6A, 8'h10);
		// Cool down, then power on again with the shutdown kept armed
		temp_value <= 8'h00;
		idle(6);
		wr(8'h60, 8'h05);
		idle(2);
		check("trip", thermal_trip, 8'h00);
		check("osc", osc_run, 8'h01);
		$display("test thermal done");
		finish_test;
	end
endmodule
